// file: lorc_pkg.sv
// constants, register map and field layout for the led output control register bank
package lorc_pkg;
    localparam int OUT_COUNT = 9;
    localparam int DUTY_W = 8;
    localparam int FINE_W = 12;
    localparam int TEMP_W = 8;
    localparam int FADER_COUNT = 3;
    // printed offsets are register indices; byte address is four times the index
    localparam logic [5:0] IDX_ENABLE_UPPER = 6'h04;
    localparam logic [5:0] IDX_ENABLE_LOWER = 6'h05;
    localparam logic [5:0] IDX_CONTROL_FIRST = 6'h06;
    localparam logic [5:0] IDX_CONTROL_LAST = 6'h0E;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 7;
    // control register fields
    localparam int FADER_MSB = 7;
    localparam int FADER_LSB = 6;
    localparam int LOG_BIT = 5;
    localparam int SLOPE_MSB = 4;
    localparam int SLOPE_LSB = 0;
    localparam int SLOPE_SIGN = 4;
    localparam logic [1:0] FADER_NONE = 2'h0;
    localparam logic [4:0] SLOPE_OFF = 5'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [8:0] ENABLE_RESET = 9'h000;
    // compensation arithmetic: slope steps are tenths, result is halved
    localparam int REF_TEMP_C = 25;
    localparam int SLOPE_STEPS_PER_UNIT = 10;
    localparam int COMP_DIVIDE = 2;
    localparam int FINE_SHIFT = FINE_W - DUTY_W;
    localparam logic [11:0] FINE_FULL = 12'hFFF;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
endpackage : lorc_pkg

// file: lorc_duty.sv
// per-output duty path: source select, fader, linear or log scale, thermal compensation
`timescale 1ns/1ns
module lorc_duty #(
    parameter int DUTY_W = lorc_pkg::DUTY_W,
    parameter int FINE_W = lorc_pkg::FINE_W,
    parameter int TEMP_W = lorc_pkg::TEMP_W
) (
    input wire logic hclk, // core clock
    input wire logic hresetn, // async reset, active low
    input wire logic [DUTY_W-1:0] set_duty, // software pwm value
    input wire logic engine_sel, // engine owns this output
    input wire logic [DUTY_W-1:0] engine_duty, // engine pwm value
    input wire logic [DUTY_W-1:0] fader_value, // value of the mapped fader
    input wire logic [1:0] fader_select, // fader mapping field
    input wire logic log_scale, // logarithmic scaling
    input wire logic [4:0] thermal_slope, // sign-magnitude slope
    input wire logic signed [TEMP_W-1:0] die_temp, // die temperature in degrees
    output logic [FINE_W-1:0] duty_reg // final 12-bit duty
);
    logic [DUTY_W-1:0] base;
    logic [2*DUTY_W-1:0] faded;
    logic [2*DUTY_W-1:0] squared;
    logic [FINE_W-1:0] scaled;
    logic signed [31:0] delta;
    logic signed [31:0] term;
    logic signed [31:0] comp;
    logic [FINE_W-1:0] duty_next;

    always_comb begin
        base = engine_sel ? engine_duty : set_duty;
        if (fader_select == lorc_pkg::FADER_NONE) begin
            faded = {base, {DUTY_W{1'b0}}};
        end else begin
            faded = base * fader_value;
        end
        // square law stands in for the log curve; the low four bits of the 16-bit square are dropped
        squared = faded[2*DUTY_W-1:DUTY_W] * faded[2*DUTY_W-1:DUTY_W];
        scaled = log_scale ? squared[2*DUTY_W-1 -: FINE_W] : faded[2*DUTY_W-1 -: FINE_W];
        delta = 32'(lorc_pkg::REF_TEMP_C) - 32'(die_temp);
        term = delta * $signed({28'h0, thermal_slope[3:0]}) * $signed({20'h0, scaled});
        if (thermal_slope[lorc_pkg::SLOPE_SIGN]) begin
            term = -term;
        end
        comp = ($signed({20'h0, scaled}) * 32'(lorc_pkg::SLOPE_STEPS_PER_UNIT) - term)
            / 32'(lorc_pkg::SLOPE_STEPS_PER_UNIT * lorc_pkg::COMP_DIVIDE);
        if (thermal_slope == lorc_pkg::SLOPE_OFF) begin
            duty_next = scaled;
        end else if (comp < 0) begin
            duty_next = '0;
        end else if (comp > 32'(lorc_pkg::FINE_FULL)) begin
            duty_next = lorc_pkg::FINE_FULL;
        end else begin
            duty_next = comp[FINE_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            duty_reg <= '0;
        end else begin
            duty_reg <= duty_next;
        end
    end
endmodule : lorc_duty

// file: lorc_regs.sv
// led output control register bank: ahb-lite slave, enables, control fields, duty paths
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ns
module lorc_regs #(
    parameter int OUT_COUNT = lorc_pkg::OUT_COUNT,
    parameter int DUTY_W = lorc_pkg::DUTY_W,
    parameter int FINE_W = lorc_pkg::FINE_W,
    parameter int TEMP_W = lorc_pkg::TEMP_W
) (
    input wire logic hclk, // core clock, 250 MHz
    input wire logic hresetn, // async reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic hreadyout, // slave ready
    output logic [31:0] hrdata, // read data
    output logic hresp, // response, always okay
    input wire logic [OUT_COUNT*DUTY_W-1:0] set_duty, // per-output pwm register values
    input wire logic [OUT_COUNT-1:0] engine_sel, // engine owns the output
    input wire logic [OUT_COUNT-1:0] engine_on, // engine on/off for owned outputs
    input wire logic [OUT_COUNT*DUTY_W-1:0] engine_duty, // engine pwm values
    input wire logic [lorc_pkg::FADER_COUNT*DUTY_W-1:0] fader_values, // master faders 1..3
    input wire logic signed [TEMP_W-1:0] die_temp, // sensor temperature, degrees
    output logic [OUT_COUNT-1:0] out_active, // output current source on
    output logic [OUT_COUNT*FINE_W-1:0] out_duty // final duty per output
);
    logic [OUT_COUNT-1:0] enable_reg;
    logic [7:0] control_reg [OUT_COUNT];
    logic dphase_reg;
    logic dwrite_reg;
    logic [5:0] didx_reg;
    logic [OUT_COUNT-1:0] active_next;
    logic [OUT_COUNT*FINE_W-1:0] duty_bus;
    logic wr_en;

    // true when the index names a control register
    function automatic logic is_control(input logic [5:0] idx);
        return idx >= lorc_pkg::IDX_CONTROL_FIRST && idx <= lorc_pkg::IDX_CONTROL_LAST;
    endfunction : is_control

    function automatic logic [3:0] control_slot(input logic [5:0] idx);
        logic [5:0] diff;
        diff = idx - lorc_pkg::IDX_CONTROL_FIRST;
        return diff[3:0];
    endfunction : control_slot

    // zero-wait slave; a word at any size is accepted, narrow writes still use the low lane
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wr_en = dphase_reg && dwrite_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dphase_reg <= 1'b0;
            dwrite_reg <= 1'b0;
            didx_reg <= '0;
        end else if (hready) begin
            dphase_reg <= hsel && (htrans == lorc_pkg::HTRANS_NONSEQ
                || htrans == lorc_pkg::HTRANS_SEQ);
            dwrite_reg <= hwrite;
            didx_reg <= haddr[lorc_pkg::IDX_MSB:lorc_pkg::IDX_LSB];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_reg <= lorc_pkg::ENABLE_RESET;
        end else if (wr_en && didx_reg == lorc_pkg::IDX_ENABLE_UPPER) begin
            enable_reg[OUT_COUNT-1] <= hwdata[0];
        end else if (wr_en && didx_reg == lorc_pkg::IDX_ENABLE_LOWER) begin
            enable_reg[OUT_COUNT-2:0] <= hwdata[OUT_COUNT-2:0];
        end
    end

    generate
        for (genvar i = 0; i < OUT_COUNT; i++) begin : g_ctrl
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    control_reg[i] <= lorc_pkg::CONTROL_RESET;
                end else if (wr_en && is_control(didx_reg)
                    && control_slot(didx_reg) == 4'(i)) begin
                    control_reg[i] <= hwdata[7:0];
                end
            end
        end
    endgenerate

    // reads return stored state; unmapped indices read zero
    always_comb begin
        hrdata = lorc_pkg::RDATA_ZERO;
        if (dphase_reg && !dwrite_reg) begin
            if (didx_reg == lorc_pkg::IDX_ENABLE_UPPER) begin
                hrdata[0] = enable_reg[OUT_COUNT-1];
            end else if (didx_reg == lorc_pkg::IDX_ENABLE_LOWER) begin
                hrdata[OUT_COUNT-2:0] = enable_reg[OUT_COUNT-2:0];
            end else if (is_control(didx_reg)) begin
                hrdata[7:0] = control_reg[control_slot(didx_reg)];
            end
        end
    end

    assign active_next = (engine_sel & engine_on) | (~engine_sel & enable_reg);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_active <= '0;
        end else begin
            out_active <= active_next;
        end
    end

    generate
        for (genvar i = 0; i < OUT_COUNT; i++) begin : g_duty
            logic [1:0] fsel;
            logic [DUTY_W-1:0] fval;
            assign fsel = control_reg[i][lorc_pkg::FADER_MSB:lorc_pkg::FADER_LSB];
            // fader code n picks fader n; code zero is unused by the duty path
            assign fval = (fsel == lorc_pkg::FADER_NONE) ? '0 :
                fader_values[(32'(fsel) - 1) * DUTY_W +: DUTY_W];
            lorc_duty #(
                .DUTY_W(DUTY_W),
                .FINE_W(FINE_W),
                .TEMP_W(TEMP_W)
            ) u_duty (
                .hclk(hclk),
                .hresetn(hresetn),
                .set_duty(set_duty[i*DUTY_W +: DUTY_W]),
                .engine_sel(engine_sel[i]),
                .engine_duty(engine_duty[i*DUTY_W +: DUTY_W]),
                .fader_value(fval),
                .fader_select(fsel),
                .log_scale(control_reg[i][lorc_pkg::LOG_BIT]),
                .thermal_slope(control_reg[i][lorc_pkg::SLOPE_MSB:lorc_pkg::SLOPE_LSB]),
                .die_temp(die_temp),
                .duty_reg(duty_bus[i*FINE_W +: FINE_W])
            );
        end
    endgenerate

    assign out_duty = duty_bus;

    // checks on output one's path and the register file
    logic first_reg;
    logic [7:0] ctrl0;
    logic [DUTY_W-1:0] sd0;
    logic [2*DUTY_W-1:0] sq0;
    logic [2*DUTY_W-1:0] fp0;
    assign ctrl0 = control_reg[0];
    assign sd0 = set_duty[DUTY_W-1:0];
    assign sq0 = sd0 * sd0;
    assign fp0 = sd0 * fader_values[DUTY_W-1:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            first_reg <= 1'b1;
        end else begin
            first_reg <= 1'b0;
        end
    end

    property p_enable_upper;
        @(posedge hclk) disable iff (!hresetn)
        wr_en && didx_reg == lorc_pkg::IDX_ENABLE_UPPER |=>
            enable_reg[OUT_COUNT-1] == $past(hwdata[0]) ##1
            out_active[OUT_COUNT-1] == ($past(engine_sel[OUT_COUNT-1])
            ? $past(engine_on[OUT_COUNT-1]) : $past(enable_reg[OUT_COUNT-1]));
    endproperty
    a_enable_upper: assert property (p_enable_upper) else $error("upper enable write lost");

    property p_enable_lower;
        @(posedge hclk) disable iff (!hresetn)
        wr_en && didx_reg == lorc_pkg::IDX_ENABLE_LOWER |=>
            enable_reg[OUT_COUNT-2:0] == $past(hwdata[OUT_COUNT-2:0]);
    endproperty
    a_enable_lower: assert property (p_enable_lower) else $error("lower enable write lost");

    property p_engine_override;
        @(posedge hclk) disable iff (!hresetn)
        engine_sel[0] |=> out_active[0] == $past(engine_on[0]);
    endproperty
    a_engine_override: assert property (p_engine_override) else $error("engine not in control");

    property p_fader_field;
        @(posedge hclk) disable iff (!hresetn)
        wr_en && didx_reg == lorc_pkg::IDX_CONTROL_FIRST |=>
            ctrl0[lorc_pkg::FADER_MSB:lorc_pkg::FADER_LSB] == $past(hwdata[7:6]);
    endproperty
    a_fader_field: assert property (p_fader_field) else $error("fader map not stored");

    property p_fader_product;
        @(posedge hclk) disable iff (!hresetn)
        !engine_sel[0] && ctrl0 == 8'h40 |=> duty_bus[FINE_W-1:0] == $past(fp0[15:4]);
    endproperty
    a_fader_product: assert property (p_fader_product) else $error("fader product wrong");

    property p_log_scale;
        @(posedge hclk) disable iff (!hresetn)
        !engine_sel[0] && ctrl0 == 8'h20 |=> duty_bus[FINE_W-1:0] == $past(sq0[15:4]);
    endproperty
    a_log_scale: assert property (p_log_scale) else $error("log scaling wrong");

    property p_linear_coarse;
        @(posedge hclk) disable iff (!hresetn)
        ctrl0 == 8'h00 |=> duty_bus[lorc_pkg::FINE_SHIFT-1:0] == '0;
    endproperty
    a_linear_coarse: assert property (p_linear_coarse) else $error("linear has fine bits");

    property p_slope_field;
        @(posedge hclk) disable iff (!hresetn)
        wr_en && didx_reg == lorc_pkg::IDX_CONTROL_FIRST |=>
            ctrl0[lorc_pkg::SLOPE_MSB:lorc_pkg::SLOPE_LSB] == $past(hwdata[4:0])
            && ctrl0[lorc_pkg::LOG_BIT] == $past(hwdata[5]);
    endproperty
    a_slope_field: assert property (p_slope_field) else $error("slope not stored");

    property p_comp_off;
        @(posedge hclk) disable iff (!hresetn)
        !engine_sel[0] && ctrl0 == 8'h00 |=> duty_bus[FINE_W-1:0] == {$past(sd0), 4'h0};
    endproperty
    a_comp_off: assert property (p_comp_off) else $error("duty not set by pwm value");

    property p_comp_ref_temp;
        @(posedge hclk) disable iff (!hresetn)
        !engine_sel[0] && ctrl0 == 8'h0F && die_temp == 8'sd25
            |=> duty_bus[FINE_W-1:0] == {1'b0, $past(sd0), 3'h0};
    endproperty
    a_comp_ref_temp: assert property (p_comp_ref_temp) else $error("reference not halved");

    property p_comp_floor;
        @(posedge hclk) disable iff (!hresetn)
        ctrl0 == 8'h0F && die_temp == -8'sd10 |=> duty_bus[FINE_W-1:0] == '0;
    endproperty
    a_comp_floor: assert property (p_comp_floor) else $error("no saturation at zero");

    property p_reset_clear;
        @(posedge hclk) disable iff (!hresetn)
        first_reg |-> enable_reg == '0 && ctrl0 == '0 && out_active == '0;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("state not clear at reset");

    c_enable_write: cover property (@(posedge hclk) disable iff (!hresetn)
        wr_en && didx_reg == lorc_pkg::IDX_ENABLE_LOWER);
    c_engine_takes: cover property (@(posedge hclk) disable iff (!hresetn)
        engine_sel[0] && !enable_reg[0] ##1 out_active[0]);
    c_comp_active: cover property (@(posedge hclk) disable iff (!hresetn)
        ctrl0[4:0] != lorc_pkg::SLOPE_OFF && duty_bus[FINE_W-1:0] != '0);
    c_log_mode: cover property (@(posedge hclk) disable iff (!hresetn)
        ctrl0[lorc_pkg::LOG_BIT] && duty_bus[3:0] != 4'h0);
endmodule : lorc_regs

// file: test_led_output_control_regs.sv
// self-checking bench for the led output control register bank
`timescale 1ns/1ns
module test_led_output_control_regs;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] temp;
        logic [11:0] duty;
    } lorc_row_s;

    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic [71:0] set_duty;
    logic [8:0] engine_sel;
    logic [8:0] engine_on;
    logic [71:0] engine_duty;
    logic [23:0] fader_values;
    logic signed [7:0] die_temp;
    logic [8:0] out_active;
    logic [107:0] out_duty;
    int bad_count;
    int total_checks;
    logic [31:0] rd;
    // output one with pwm 0x80, faders 0x40/0x80/0xFF; expected 12-bit duty per row
    lorc_row_s rows [12] = '{
        '{8'h00, 8'h19, 12'h800}, '{8'h40, 8'h19, 12'h200}, '{8'h80, 8'h19, 12'h400},
        '{8'hC0, 8'h19, 12'h7F8}, '{8'h20, 8'h19, 12'h400}, '{8'h60, 8'h19, 12'h040},
        '{8'h0F, 8'h19, 12'h400}, '{8'h0F, 8'hF6, 12'h000}, '{8'h1F, 8'hF6, 12'hFFF},
        '{8'h01, 8'h14, 12'h200}, '{8'h11, 8'h14, 12'h600}, '{8'h0E, 8'h18, 12'h000}};

    lorc_regs lorc_regs_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .set_duty(set_duty),
        .engine_sel(engine_sel), .engine_on(engine_on), .engine_duty(engine_duty),
        .fader_values(fader_values), .die_temp(die_temp), .out_active(out_active),
        .out_duty(out_duty)
    );

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    // one single transfer; the master holds each phase until hready is seen high
    task automatic bus_xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= lorc_pkg::HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        check({31'h0, hresp}, 32'h0);
        check({31'h0, hreadyout}, 32'h1);
    endtask : bus_xfer

    task automatic reg_rw(input logic [31:0] a, input logic [31:0] d, input logic [31:0] exp);
        bus_xfer(1'b1, a, d);
        bus_xfer(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : reg_rw

    initial begin
        #20000;
        bad_count++;
        summarize();
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        set_duty = {9{8'h80}};
        engine_sel = 9'h000;
        engine_on = 9'h000;
        engine_duty = {9{8'h40}};
        fader_values = {8'hFF, 8'h80, 8'h40};
        die_temp = 8'sh19;
        bad_count = 0;
        total_checks = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        check({23'h0, out_active}, 32'h0);
        bus_xfer(1'b0, 32'h18, 32'h0);
        check(rd, 32'h0);
        foreach (rows[i]) begin
            die_temp <= rows[i].temp;
            reg_rw(32'h18, {24'hFFFFFF, rows[i].ctrl}, {24'h0, rows[i].ctrl});
            repeat (2) @(posedge hclk);
            check({20'h0, out_duty[11:0]}, {20'h0, rows[i].duty});
        end
        // enables: upper keeps only bit 0 for output nine
        reg_rw(32'h10, 32'hFFFF_FFFF, 32'h1);
        reg_rw(32'h14, 32'h0000_00A5, 32'hA5);
        repeat (2) @(posedge hclk);
        check({23'h0, out_active}, 32'h1A5);
        // output one in log mode: the engine's 0x40 must be squared as well
        reg_rw(32'h18, 32'h0000_0020, 32'h20);
        engine_sel <= 9'h003;
        engine_on <= 9'h002;
        repeat (3) @(posedge hclk);
        check({23'h0, out_active}, 32'h1A6);
        check({20'h0, out_duty[11:0]}, 32'h100);
        check({20'h0, out_duty[23:12]}, 32'h400);
        check({20'h0, out_duty[35:24]}, 32'h800);
        engine_sel <= 9'h000;
        for (int i = 1; i < 9; i++) begin
            reg_rw(32'h18 + 4 * i, 32'hFFFF_FF00 | (i * 32'h15), (i * 32'h15) & 32'hFF);
        end
        // unmapped and out-of-block places read zero and ignore writes
        reg_rw(32'h40, 32'hFFFF_FFFF, 32'h0);
        reg_rw(32'h0C, 32'hFFFF_FFFF, 32'h0);
        // second reset in mid-run clears every field
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        check({23'h0, out_active}, 32'h0);
        bus_xfer(1'b0, 32'h10, 32'h0);
        check(rd, 32'h0);
        bus_xfer(1'b0, 32'h14, 32'h0);
        check(rd, 32'h0);
        bus_xfer(1'b0, 32'h38, 32'h0);
        check(rd, 32'h0);
        summarize();
    end
endmodule : test_led_output_control_regs
